// ---- spims_far_slave.sv ----
// Behavioural far-end slave for master traffic, clock mode 0
`timescale 1ns/1ps
module spims_far_slave (
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // Bench side
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic last = 1'b0;
    // Load on select; the bench selects one slave and holds it low per byte
    always @(negedge ss_n) begin
        sh = tx_byte;
    end
    // Released line shows the inverse of the last bit
    assign miso = ss_n ? ~last : (lsb ? sh[0] : sh[7]);
    // Sample on the leading edge
    always @(posedge sck) begin
        if (!ss_n) begin
            rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
        end
    end
    // Shift on the trailing edge
    always @(negedge sck) begin
        if (!ss_n) begin
            last = miso;
            sh = lsb ? sh >> 1 : sh << 1;
        end
    end
endmodule

// ---- spims_params.svh ----
// Constants for the serial master/slave port
`ifndef SPIMS_PARAMS_SVH
`define SPIMS_PARAMS_SVH
`define SPIMS_BYTE_W 8
`define SPIMS_FIFO_DEPTH 16
`define SPIMS_HALF_MIN 7'h02
`define SPIMS_HALF_MAX 7'h40
`define SPIMS_RATE_LAST 3'h4
`define SPIMS_EDGE_LAST 4'hf
`define SPIMS_IDLE_BYTE 8'h00
`define SPIMS_CTRL_RST 9'h000
`endif

// ---- spims_pkg.sv ----
// Types shared by the serial master/slave port
package spims_pkg;
    // Control word as software writes it
    typedef struct packed {
        logic       en;
        logic       lsb_first;
        logic       master_select;
        logic       clock_phase_sel;
        logic       clock_polarity_sel;
        logic       select_pin_disable;
        logic [2:0] rate;
    } spims_ctrl_t;
    // Sticky status flags
    typedef struct packed {
        logic done;
        logic mode_fault_flag;
        logic write_collision_flag;
        logic receive_overrun_flag;
    } spims_stat_t;
    // Flag clear pulses
    typedef struct packed {
        logic done;
        logic mode_fault_flag;
        logic write_collision_flag;
        logic receive_overrun_flag;
    } spims_clr_t;
    typedef enum logic {MS_IDLE, MS_RUN} spims_mstate_t;
endpackage

// ---- spims_port.sv ----
// Serial master/slave port with receive stream FIFO
`timescale 1ns/1ps
`include "spims_params.svh"

// -------------------------------------------------
// Receive stream FIFO
// -------------------------------------------------
module spims_fifo #(
    parameter int W = `SPIMS_BYTE_W,
    parameter int DEPTH = `SPIMS_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    // Full and empty from pointers with wrap bit
    always_comb begin
        in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
        out_valid = (wp_q != rp_q);
        out_data = mem_q[rp_q[AW-1:0]];
        push = ce && in_valid && in_ready;
        pop = ce && out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    // Pointer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage, written on push only
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// -------------------------------------------------
// Port core
// -------------------------------------------------
// Functional notes
// - Master clock divides by 4 to 128
// - Rate code 000 is /4, above 100 /128
// - Master drives eight clock cycles per byte
// - Unselected slave floats its data output
// - Unselected slave ignores serial clock
// - Master with pin disable: no mode fault
// - Slave, phase 1 and disable: always selected
// - Phase 0: select falling edge starts byte
// - Phase picks first or second sampling edge
// - Data write loads shifter, read gives buffer
// - Master select chooses master or slave role
// - Master write to idle shifter starts transfer
// - Write during transfer flags collision, ignored
// - Byte end sets done flag and interrupt
// - Bit order selectable, MSB or LSB first
// - Completed byte moves into receive buffer
// - Byte before done cleared: overrun, kept
// - Slave counts clock edges, done after sixteen
// - Slave never starts a transfer itself
// - Late slave write sends zero byte
// - Master select low: fault, disable, slave
module spims_port (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control and status
    input wire logic ctrl_we,
    input wire spims_pkg::spims_ctrl_t ctrl_wdata,
    output spims_pkg::spims_ctrl_t ctrl_rdata,
    input wire spims_pkg::spims_clr_t flag_clr,
    output spims_pkg::spims_stat_t stat,
    input wire logic irq_en,
    output logic irq,
    output logic ss_gpio_free,
    // Data access
    input wire logic dat_wr,
    output logic dat_wr_ready,
    input wire logic [7:0] dat_wdata,
    output logic [7:0] dat_rdata,
    // Received byte stream
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Serial pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i
);
    spims_pkg::spims_ctrl_t ctrl_q, ctrl_d;
    spims_pkg::spims_stat_t stat_q, stat_d;
    spims_pkg::spims_mstate_t state_q, state_d;
    logic [6:0] div_q, div_d, half;
    logic [3:0] ecnt_q, ecnt_d;
    logic [7:0] sh_q, sh_d, rxbuf_q, rxbuf_d, fin;
    logic smp_q, smp_d, sck_q, sck_d, txf_q, txf_d, armed_q, armed_d, mev_q, mev_d;
    logic [3:0] s1_q, s2_q, s3_q;
    logic selected, slave_act, edge_ev, bit_ev, lead, sample, in_bit, busy, last;
    logic wr_acc, coll, fault, push, fifo_rdy, outbit;

    // Shift one bit in, order per bit-order select
    function automatic logic [7:0] shin(input logic [7:0] v, input logic b, input logic lsb);
        shin = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    // Two-flop synchronisers plus edge history: {sck, mosi, miso, ss_n}
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 4'h1;
            s2_q <= 4'h1;
            s3_q <= 4'h1;
        end else if (ce) begin
            s1_q <= {sck_i, mosi_i, miso_i, ss_n_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Decode of role, selection and clock edges
    always_comb begin
        half = (ctrl_q.rate > `SPIMS_RATE_LAST) ? `SPIMS_HALF_MAX
             : 7'(`SPIMS_HALF_MIN << ctrl_q.rate);
        selected = !s2_q[0] || (ctrl_q.clock_phase_sel && ctrl_q.select_pin_disable);
        slave_act = ctrl_q.en && !ctrl_q.master_select && selected;
        // Slave edges only from the master's clock while selected
        edge_ev = ctrl_q.master_select ? (state_q == spims_pkg::MS_RUN && div_q == half - 7'h01)
                : (slave_act && armed_q && (s2_q[3] != s3_q[3]));
        bit_ev = ctrl_q.master_select ? mev_q : edge_ev; // Master waits a cycle for synced data
        lead = !ecnt_q[0];
        sample = lead ^ ctrl_q.clock_phase_sel;
        in_bit = ctrl_q.master_select ? s2_q[1] : s2_q[2];
        busy = ctrl_q.master_select ? (state_q == spims_pkg::MS_RUN) : (ecnt_q != 4'h0);
        last = bit_ev && ecnt_q == `SPIMS_EDGE_LAST;
        fin = shin(sh_q, ctrl_q.clock_phase_sel ? in_bit : smp_q, ctrl_q.lsb_first);
        coll = busy || txf_q;
        dat_wr_ready = fifo_rdy || !ctrl_q.master_select;
        wr_acc = ce && dat_wr && dat_wr_ready;
        fault = ctrl_q.en && ctrl_q.master_select && !ctrl_q.select_pin_disable && !s2_q[0];
        outbit = ctrl_q.lsb_first ? sh_q[0] : sh_q[7];
    end

    // Next-state logic for the whole engine
    always_comb begin
        ctrl_d = ctrl_we ? ctrl_wdata : ctrl_q;
        stat_d = stat_q;
        state_d = state_q;
        div_d = div_q;
        ecnt_d = ecnt_q;
        sh_d = sh_q;
        smp_d = smp_q;
        sck_d = sck_q;
        txf_d = txf_q;
        armed_d = armed_q;
        mev_d = ctrl_q.master_select && edge_ev && !fault;
        rxbuf_d = rxbuf_q;
        push = 1'b0;
        // Software clears; hardware sets below override
        if (flag_clr.done) stat_d.done = 1'b0;
        if (flag_clr.mode_fault_flag) stat_d.mode_fault_flag = 1'b0;
        if (flag_clr.write_collision_flag) stat_d.write_collision_flag = 1'b0;
        if (flag_clr.receive_overrun_flag) stat_d.receive_overrun_flag = 1'b0;
        // Slave arming: phase 0 needs a select falling edge
        if (ctrl_q.clock_phase_sel) begin
            armed_d = 1'b1;
        end else if (!ctrl_q.master_select && s3_q[0] && !s2_q[0]) begin
            armed_d = 1'b1;
            ecnt_d = 4'h0;
        end
        if (!ctrl_q.master_select && !selected) begin
            ecnt_d = 4'h0;
        end
        // Data write: load shifter or flag a collision
        if (wr_acc) begin
            if (coll) begin
                stat_d.write_collision_flag = 1'b1;
            end else begin
                sh_d = dat_wdata;
                txf_d = 1'b1;
                if (ctrl_q.master_select && ctrl_q.en) begin
                    state_d = spims_pkg::MS_RUN;
                    div_d = 7'h00;
                    ecnt_d = 4'h0;
                end
            end
        end
        // Master clock divider
        if (state_q == spims_pkg::MS_RUN) begin
            div_d = edge_ev ? 7'h00 : div_q + 7'h01;
            if (edge_ev) sck_d = !sck_q;
        end else begin
            sck_d = ctrl_q.clock_polarity_sel;
        end
        // Bit engine on each serial clock edge
        if (bit_ev) begin
            ecnt_d = ecnt_q + 4'h1;
            if (last) begin
                sh_d = `SPIMS_IDLE_BYTE;
                txf_d = 1'b0;
                ecnt_d = 4'h0;
                state_d = spims_pkg::MS_IDLE;
                if (!ctrl_q.clock_phase_sel) armed_d = 1'b0;
                if (stat_q.done && !flag_clr.done) begin
                    stat_d.receive_overrun_flag = 1'b1;
                end else begin
                    rxbuf_d = fin;
                    stat_d.done = 1'b1;
                    push = 1'b1;
                end
            end else if (sample) begin
                smp_d = in_bit;
            end else if (ecnt_q != 4'h0) begin
                sh_d = shin(sh_q, smp_q, ctrl_q.lsb_first);
            end
        end
        // Mode fault drops the port out of master role
        if (fault) begin
            stat_d.mode_fault_flag = 1'b1;
            ctrl_d.en = 1'b0;
            ctrl_d.master_select = 1'b0;
            state_d = spims_pkg::MS_IDLE;
            ecnt_d = 4'h0;
            txf_d = 1'b0;
            push = 1'b0;
        end
    end

    // Engine registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SPIMS_CTRL_RST;
            stat_q <= '0;
            state_q <= spims_pkg::MS_IDLE;
            div_q <= 7'h00;
            ecnt_q <= 4'h0;
            sh_q <= `SPIMS_IDLE_BYTE;
            smp_q <= 1'b0;
            sck_q <= 1'b0;
            txf_q <= 1'b0;
            armed_q <= 1'b0;
            mev_q <= 1'b0;
            rxbuf_q <= `SPIMS_IDLE_BYTE;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            state_q <= state_d;
            div_q <= div_d;
            ecnt_q <= ecnt_d;
            sh_q <= sh_d;
            smp_q <= smp_d;
            sck_q <= sck_d;
            txf_q <= txf_d;
            armed_q <= armed_d;
            mev_q <= mev_d;
            rxbuf_q <= rxbuf_d;
        end
    end

    // Received bytes queue; full FIFO holds off master writes
    spims_fifo #(.W(`SPIMS_BYTE_W), .DEPTH(`SPIMS_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_rdy),
        .in_data(fin),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // Pin drivers and status outputs
    always_comb begin
        ctrl_rdata = ctrl_q;
        stat = stat_q;
        dat_rdata = rxbuf_q;
        irq = irq_en && (stat_q.done || stat_q.mode_fault_flag);
        ss_gpio_free = ctrl_q.select_pin_disable && (ctrl_q.master_select || ctrl_q.clock_phase_sel);
        sck_o = sck_q;
        sck_oe = ctrl_q.en && ctrl_q.master_select;
        mosi_o = outbit;
        mosi_oe = ctrl_q.en && ctrl_q.master_select;
        miso_o = outbit;
        miso_oe = slave_act;
    end

    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_miso_float: assert property (!ctrl_q.master_select && !selected |-> !miso_oe)
        else $error("unselected slave drives data out");
    a_sck_ignored: assert property (ce && !ctrl_q.master_select && !selected |=> ecnt_q == 4'h0)
        else $error("unselected slave counted clock edges");
    a_mode_fault_flag_blocked: assert property (ce && ctrl_q.select_pin_disable && !stat_q.mode_fault_flag && !ctrl_we
        |=> !stat_q.mode_fault_flag)
        else $error("mode fault set with pin disabled");
    a_mode_fault_flag_effect: assert property (ce && fault |=> stat_q.mode_fault_flag && !ctrl_q.en && !ctrl_q.master_select)
        else $error("mode fault did not disable master");
    a_master_start: assert property (ce && wr_acc && !coll && ctrl_q.master_select && ctrl_q.en && !fault
        |=> state_q == spims_pkg::MS_RUN)
        else $error("master write did not start transfer");
    a_write_collision_flag_keep: assert property (ce && wr_acc && coll && !bit_ev && !fault
        |=> stat_q.write_collision_flag && $stable(sh_q))
        else $error("collision write changed shifter");
    a_done_set: assert property (ce && last && !stat_q.done && !fault
        |=> stat_q.done && rxbuf_q == $past(fin))
        else $error("byte end did not set done and buffer");
    a_ovr_keep: assert property (ce && last && stat_q.done && !flag_clr.done && !fault
        |=> stat_q.receive_overrun_flag && $stable(rxbuf_q))
        else $error("overrun lost or replaced byte");
    a_sck_idle: assert property (ce && ctrl_q.master_select && last |=> sck_q == ctrl_q.clock_polarity_sel)
        else $error("serial clock not idle after eight cycles");
    a_half_div: assert property (ce && state_q == spims_pkg::MS_RUN && edge_ev && !fault
        |=> div_q == 7'h00)
        else $error("divider did not restart on edge");

    c_master_byte: cover property (ctrl_q.master_select && last);
    c_slave_byte: cover property (!ctrl_q.master_select && last);
    c_overrun: cover property ($rose(stat_q.receive_overrun_flag));
    c_mode_fault: cover property ($rose(stat_q.mode_fault_flag));
endmodule

// ---- tb.sv ----
// Self-checking bench for the serial master/slave port
`timescale 1ns/1ps
module tb;
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_we = 1'b0;
    spims_pkg::spims_ctrl_t ctrl_wdata = '0;
    spims_pkg::spims_clr_t flag_clr = '0;
    logic dat_wr = 1'b0;
    logic [7:0] dat_wdata = 8'h00;
    logic rx_ready = 1'b0;
    logic sck_i = 1'b0;
    logic mosi_i = 1'b0;
    logic ss_n_i = 1'b1;
    logic [7:0] ps_tx = 8'h00;
    logic ps_ss_n = 1'b1;
    logic ps_lsb = 1'b0;
    logic irq_en = 1'b1;
    spims_pkg::spims_ctrl_t ctrl_rdata;
    spims_pkg::spims_stat_t stat;
    logic irq, ss_gpio_free, dat_wr_ready, rx_valid, sck_o, sck_oe, mosi_o, mosi_oe;
    logic miso_i, miso_o, miso_oe;
    logic [7:0] dat_rdata, rx_data, ps_rx, got;
    logic [7:0] exp_q[$];
    int half;
    int mismatches = 0;
    int n_checks = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    spims_port spims_port_inst (.clk, .rst_n, .ce(1'b1), .ctrl_we, .ctrl_wdata, .ctrl_rdata,
        .flag_clr, .stat, .irq_en, .irq, .ss_gpio_free, .dat_wr, .dat_wr_ready,
        .dat_wdata, .dat_rdata, .rx_valid, .rx_ready, .rx_data, .sck_i, .sck_o, .sck_oe,
        .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i);
    spims_far_slave spims_far_slave_inst (.sck(sck_o), .mosi(mosi_o), .ss_n(ps_ss_n),
        .miso(miso_i), .lsb(ps_lsb), .tx_byte(ps_tx), .rx_byte(ps_rx));
    // Access and compare tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: byte %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: flag %b, expected %b", $time, g, e);
        end
    endtask
    task automatic set_ctrl(input logic [8:0] v);
        ctrl_wdata = spims_pkg::spims_ctrl_t'(v);
        ctrl_we = 1'b1;
        tick(1);
        ctrl_we = 1'b0;
    endtask
    task automatic clr(input logic [3:0] m);
        flag_clr = spims_pkg::spims_clr_t'(m);
        tick(1);
        flag_clr = '0;
    endtask
    task automatic wr(input logic [7:0] b);
        dat_wdata = b;
        dat_wr = 1'b1;
        tick(1);
        dat_wr = 1'b0;
    endtask
    // Master byte exchange; counts clock toggles and measures half period
    task automatic mxfer(input logic [7:0] w, input logic [7:0] p, input logic coll);
        int n, t, t1;
        logic prev;
        n = 0;
        t = 0;
        t1 = 0;
        ps_tx = p;
        ps_ss_n = 1'b0;
        tick(1);
        wr(w);
        prev = sck_o;
        while (n < 16 && t < 3000) begin
            tick(1);
            t++;
            if (sck_o !== prev) begin
                n++;
                if (n == 1) t1 = t;
                if (n == 2) half = t - t1;
            end
            prev = sck_o;
            dat_wdata = 8'hff;
            if (coll) dat_wr = (n == 4);
        end
        tick(3);
        ps_ss_n = 1'b1;
        if (t >= 3000) begin
            mismatches++;
            $display("mismatch at %0t: serial clock stalled", $time);
        end
    endtask
    // Bench acts as master toward the slave role, clock mode 0 or 1
    task automatic sxfer(input logic [7:0] tx, input logic clock_phase_sel, output logic [7:0] g);
        for (int i = 7; i >= 0; i--) begin
            if (!clock_phase_sel) mosi_i = tx[i];
            tick(8);
            if (!clock_phase_sel) g[i] = miso_o;
            sck_i = 1'b1;
            if (clock_phase_sel) mosi_i = tx[i];
            tick(8);
            if (clock_phase_sel) g[i] = miso_o;
            sck_i = 1'b0;
        end
        tick(8);
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #(60000 * 5);
        $display("mismatch at %0t: watchdog expired", $time);
        mismatches++;
        report_and_stop();
    end
    // Test sequence
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(1);
        chk8({ctrl_rdata.lsb_first, ctrl_rdata[6:0]}, 8'h00);
        chk8({4'h0, stat}, 8'h00);
        chk8(dat_rdata, 8'h00);
        chk1(sck_oe, 1'b0);
        chk1(rx_valid, 1'b0);
        $display("test reset values done");
        for (int k = 0; k < 16; k++) begin
            set_ctrl({6'h29, (k < 8) ? k[2:0] : 3'h0});
            mxfer({4'h3, k[3:0]}, {4'hc, k[3:0]}, 1'b0);
            chk8(ps_rx, {4'h3, k[3:0]});
            chk8(dat_rdata, {4'hc, k[3:0]});
            chk1(stat.done, 1'b1);
            chk1(irq, 1'b1);
            chk1(sck_o, 1'b0);
            if (k < 8) chk8(half[7:0], (k > 4) ? 8'h40 : (8'h02 << k[2:0]));
            exp_q.push_back({4'hc, k[3:0]});
            clr(4'h8);
        end
        chk1(dat_wr_ready, 1'b0);
        rx_ready = 1'b1;
        for (int k = 0; k < 16; k++) begin
            chk1(rx_valid, 1'b1);
            chk8(rx_data, exp_q.pop_front());
            tick(1);
        end
        chk1(rx_valid, 1'b0);
        $display("test master rates and stream done");
        mxfer(8'h5a, 8'ha5, 1'b1);
        chk8(ps_rx, 8'h5a);
        chk1(stat.write_collision_flag, 1'b1);
        clr(4'h8);
        chk1(irq, 1'b0);
        chk1(stat.write_collision_flag, 1'b1);
        clr(4'h2);
        mxfer(8'h01, 8'h3c, 1'b0);
        mxfer(8'h02, 8'hc3, 1'b0);
        chk1(stat.receive_overrun_flag, 1'b1);
        chk8(dat_rdata, 8'h3c);
        irq_en = 1'b0;
        tick(1);
        chk1(irq, 1'b0);
        irq_en = 1'b1;
        clr(4'h9);
        mxfer(8'h03, 8'h77, 1'b0);
        chk8(dat_rdata, 8'h77);
        clr(4'h8);
        ps_lsb = 1'b1;
        set_ctrl(9'h1c8);
        mxfer(8'h1e, 8'h4b, 1'b0);
        chk8(ps_rx, 8'h1e);
        chk8(dat_rdata, 8'h4b);
        ps_lsb = 1'b0;
        clr(4'h8);
        $display("test collision, overrun, bit order done");
        set_ctrl(9'h148);
        ss_n_i = 1'b0;
        tick(6);
        chk1(stat.mode_fault_flag, 1'b0);
        chk1(ss_gpio_free, 1'b1);
        set_ctrl(9'h140);
        tick(4);
        chk1(stat.mode_fault_flag, 1'b1);
        chk1(ctrl_rdata.en, 1'b0);
        chk1(ctrl_rdata.master_select, 1'b0);
        chk1(irq, 1'b1);
        ss_n_i = 1'b1;
        clr(4'h4);
        $display("test mode fault done");
        set_ctrl(9'h100);
        wr(8'h5a);
        sxfer(8'hff, 1'b0, got);
        chk1(stat.done, 1'b0);
        chk1(miso_oe, 1'b0);
        chk1(sck_oe, 1'b0);
        chk1(mosi_oe, 1'b0);
        ss_n_i = 1'b0;
        tick(4);
        sxfer(8'h96, 1'b0, got);
        chk8(got, 8'h5a);
        chk8(dat_rdata, 8'h96);
        chk1(stat.done, 1'b1);
        clr(4'h8);
        sxfer(8'h11, 1'b0, got);
        chk1(stat.done, 1'b0);
        // Select toggles between bytes
        ss_n_i = 1'b1;
        tick(4);
        ss_n_i = 1'b0;
        tick(4);
        sxfer(8'h22, 1'b0, got);
        chk8(got, 8'h00);
        chk8(dat_rdata, 8'h22);
        ss_n_i = 1'b1;
        clr(4'h8);
        set_ctrl(9'h128);
        chk1(ss_gpio_free, 1'b1);
        wr(8'hc6);
        sxfer(8'h6c, 1'b1, got);
        chk8(got, 8'hc6);
        chk8(dat_rdata, 8'h6c);
        $display("test slave role done");
        report_and_stop();
    end
endmodule
